// File: design/plc_cpu_status.sv
`timescale 1ns/100ps
// Operation
// - accept three-position mode selector input
// - run indicator on when disable/run and scanning
// - pass indicator on after self-test completes
// - pass indicator off during program-to-run diagnostics
// - battery indicator follows battery good input
// - force indicator on while forced contact scanned
// - program memory 8K words of 24 bits
// - two-word instructions take two program words
// - timer/counter values live in register table
// - output status table of 4096 bits
// - real output range set by model variant
// - addresses above real range are internal relays
// - unused real addresses usable as internal bits
// - addresses 4096-8191 are 16-bit registers
// - two registers per timer/counter, 2048 max
// - two registers per float bring-in/send-out
// - checksum retained memory, flag corruption fault
module plc_cpu_status #(
   parameter int unsigned VARIANT = plc_status_pkg::VAR_LARGE
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic [31:0] adr_i,
   input wire logic [31:0] dat_i,
   output logic [31:0] dat_o,
   input wire logic we_i,
   input wire logic [3:0] sel_i,
   input wire logic cyc_i,
   input wire logic stb_i,
   output logic ack_o,
   input wire logic [1:0] mode_sel_i,
   input wire logic battery_ok_i,
   input wire logic scanning_i,
   input wire logic forced_scan_i,
   output logic run_led_o,
   output logic pass_led_o,
   output logic battery_good_indicator_o,
   output logic force_led_o,
   output logic checksum_fault_o,
   output logic irq_o
);
   import plc_status_pkg::*;

   localparam logic [BIT_AW-1:0] REAL_LAST = (VARIANT == VAR_SMALL) ? REAL_LAST_SMALL :
                                             (VARIANT == VAR_MEDIUM) ? REAL_LAST_MEDIUM : REAL_LAST_LARGE;
   localparam logic [PTR_W-1:0] PROG_END = PTR_W'(PROG_DEPTH);
   localparam logic [PROG_AW-1:0] SCAN_LAST = PROG_AW'(PROG_DEPTH - 1);

   logic [1:0] mode_meta;
   logic [1:0] mode_sync;
   logic bat_meta;
   logic bat_sync;
   logic bat_prev;
   mode_t mode;
   mode_t mode_prev;
   mode_t next_mode;

   logic [PROG_W-1:0] prog_mem [PROG_DEPTH];
   logic [BIT_DEPTH-1:0] out_table;
   logic [REG_W-1:0] reg_table [REG_DEPTH];

   logic [PTR_W-1:0] prog_ptr;
   logic operand_pending;
   logic [PROG_W-1:0] run_sum;
   logic [PROG_W-1:0] acc;
   logic [PROG_AW-1:0] chk_idx;
   chk_state_t chk_state;
   logic selftest_ok;
   logic learned;
   logic csum_fault;
   logic [IRQ_W-1:0] irq_status;
   logic [IRQ_W-1:0] irq_mask;
   logic [BIT_AW-1:0] class_addr;

   logic req;
   logic take;
   logic wr;
   logic chk_busy;
   logic [RGN_W-1:0] region;
   logic [OFS_W-1:0] ofs;
   logic is_ctrl;
   logic is_bit;
   logic is_dreg;
   logic is_prog;
   logic is_tc;
   logic is_fp;
   logic [BIT_AW-1:0] bit_idx;
   logic [REG_AW-1:0] reg_idx;
   logic [REG_AW-1:0] fp_lo;
   logic [REG_AW-1:0] fp_hi;
   logic [PROG_AW-1:0] prog_idx;
   logic [31:0] wmask;
   logic [31:0] next_rdata;
   logic [PROG_W-1:0] prog_new;
   logic [REG_W-1:0] reg_new;
   logic [REG_W-1:0] fp_lo_new;
   logic [REG_W-1:0] fp_hi_new;
   logic [PROG_W-1:0] app_word;
   logic [1:0] app_need;
   logic app_wr;
   logic app_ok;
   logic prog_to_run;
   logic start_chk;
   logic [IRQ_W-1:0] events;

   // first stage is read only by the second
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         mode_meta <= PIN_PROGRAM;
         mode_sync <= PIN_PROGRAM;
         bat_meta <= 1'b0;
         bat_sync <= 1'b0;
      end else begin
         mode_meta <= mode_sel_i;
         mode_sync <= mode_meta;
         bat_meta <= battery_ok_i;
         bat_sync <= bat_meta;
      end
   end

   // the unused fourth code keeps the last position, as a switch between detents would
   always_comb begin
      case (mode_sync)
         PIN_PROGRAM: next_mode = MODE_PROGRAM;
         PIN_DISABLE: next_mode = MODE_DISABLE;
         PIN_RUN: next_mode = MODE_RUN;
         default: next_mode = mode;
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         mode <= MODE_PROGRAM;
         mode_prev <= MODE_PROGRAM;
         bat_prev <= 1'b0;
      end else begin
         mode <= next_mode;
         mode_prev <= mode;
         bat_prev <= bat_sync;
      end
   end

   assign prog_to_run = (mode_prev == MODE_PROGRAM) && (mode == MODE_RUN);
   assign chk_busy = (chk_state != CHK_IDLE);

   // bus decode
   assign req = cyc_i & stb_i & ~ack_o;
   assign region = adr_i[RGN_LSB +: RGN_W];
   assign ofs = adr_i[0 +: OFS_W];
   assign is_ctrl = (adr_i[TOP_LSB +: TOP_W] == '0) && (region == RGN_CTRL)
                    && (adr_i[RGN_LSB-1:OFS_W] == '0);
   assign is_bit = (adr_i[TOP_LSB +: TOP_W] == '0) && (region == RGN_DATA) && !adr_i[DREG_BIT]
                   && !adr_i[PAIR_SEL_BIT];
   assign is_dreg = (adr_i[TOP_LSB +: TOP_W] == '0) && (region == RGN_DATA) && adr_i[DREG_BIT]
                    && !adr_i[PAIR_SEL_BIT];
   assign is_prog = (adr_i[TOP_LSB +: TOP_W] == '0) && (region == RGN_PROG)
                    && (adr_i[RGN_LSB-1:IDX_LSB+PROG_AW] == '0);
   assign is_tc = (adr_i[TOP_LSB +: TOP_W] == '0) && (region == RGN_PAIR) && !adr_i[PAIR_SEL_BIT]
                  && !adr_i[PAIR_GAP_BIT];
   assign is_fp = (adr_i[TOP_LSB +: TOP_W] == '0) && (region == RGN_PAIR) && adr_i[PAIR_SEL_BIT]
                  && !adr_i[PAIR_GAP_BIT] && !adr_i[FP_GAP_BIT];
   assign bit_idx = adr_i[IDX_LSB +: BIT_AW];
   assign prog_idx = adr_i[IDX_LSB +: PROG_AW];
   // timer n owns registers 2n (preset) and 2n+1 (accumulated)
   assign reg_idx = is_tc ? {adr_i[TC_IDX_LSB +: PAIR_AW], adr_i[TC_FIELD_BIT]}
                          : adr_i[IDX_LSB +: REG_AW];
   assign fp_lo = {adr_i[IDX_LSB +: PAIR_AW], 1'b0};
   assign fp_hi = {adr_i[IDX_LSB +: PAIR_AW], 1'b1};

   // writes that touch checksummed memory wait out a running scan
   assign take = req & ~(we_i & chk_busy & (is_prog | is_dreg | is_tc | is_fp
                 | (is_ctrl && ofs == OFS_PROG_APPEND)));
   assign wr = take & we_i;
   assign wmask = {{8{sel_i[3]}}, {8{sel_i[2]}}, {8{sel_i[1]}}, {8{sel_i[0]}}};

   assign prog_new = (prog_mem[prog_idx] & ~wmask[PROG_W-1:0]) | (dat_i[PROG_W-1:0] & wmask[PROG_W-1:0]);
   assign reg_new = (reg_table[reg_idx] & ~wmask[REG_W-1:0]) | (dat_i[REG_W-1:0] & wmask[REG_W-1:0]);
   assign fp_lo_new = (reg_table[fp_lo] & ~wmask[REG_W-1:0]) | (dat_i[REG_W-1:0] & wmask[REG_W-1:0]);
   assign fp_hi_new = (reg_table[fp_hi] & ~wmask[31:REG_W]) | (dat_i[31:REG_W] & wmask[31:REG_W]);

   // appended words: an opcode word may drag one operand word after it
   assign app_word = dat_i[PROG_W-1:0];
   assign app_wr = wr && is_ctrl && (ofs == OFS_PROG_APPEND);
   assign app_need = operand_pending ? 2'd1 : instr_words(app_word[OPC_LSB +: OPC_W]);
   assign app_ok = (prog_ptr + PTR_W'(app_need)) <= PROG_END;

   assign start_chk = prog_to_run || (wr && is_ctrl && (ofs == OFS_CTRL) && dat_i[CTRL_START]);

   always_comb begin
      next_rdata = '0;
      if (is_ctrl) begin
         case (ofs)
            OFS_STATUS: next_rdata = {20'h0, operand_pending, csum_fault, selftest_ok, chk_busy,
                                      force_led_o, battery_good_indicator_o, pass_led_o, run_led_o,
                                      scanning_i, bat_sync, mode};
            OFS_IRQ_STATUS: next_rdata = {27'h0, irq_status};
            OFS_IRQ_MASK: next_rdata = {27'h0, irq_mask};
            OFS_PROG_PTR: next_rdata = {18'h0, prog_ptr};
            OFS_CHECKSUM: next_rdata = {8'h0, run_sum};
            // bit0 real output, bit1 dedicated internal relay, bit2 usable as internal
            OFS_ADDR_CLASS: next_rdata = {17'h0, class_addr, 1'b1, class_addr > REAL_LAST,
                                          class_addr <= REAL_LAST};
            default: next_rdata = '0;
         endcase
      end else if (is_bit) begin
         next_rdata = {30'h0, bit_idx <= REAL_LAST, out_table[bit_idx]};
      end else if (is_dreg || is_tc) begin
         next_rdata = {16'h0, reg_table[reg_idx]};
      end else if (is_fp) begin
         next_rdata = {reg_table[fp_hi], reg_table[fp_lo]};
      end else if (is_prog) begin
         next_rdata = {8'h0, prog_mem[prog_idx]};
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_o <= 1'b0;
         dat_o <= '0;
      end else begin
         ack_o <= take;
         if (take && !we_i) begin
            dat_o <= next_rdata;
         end
      end
   end

   // every bit is writable whatever the variant; the split only labels addresses
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         out_table <= '0;
      end else if (wr && is_bit && sel_i[0]) begin
         out_table[bit_idx] <= dat_i[0];
      end
   end

   always_ff @(posedge clk_i) begin
      if (wr && (is_dreg || is_tc)) begin
         reg_table[reg_idx] <= reg_new;
      end else if (wr && is_fp) begin
         reg_table[fp_lo] <= fp_lo_new;
         reg_table[fp_hi] <= fp_hi_new;
      end
   end

   always_ff @(posedge clk_i) begin
      if (wr && is_prog) begin
         prog_mem[prog_idx] <= prog_new;
      end else if (app_wr && app_ok) begin
         prog_mem[prog_ptr[PROG_AW-1:0]] <= app_word;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         prog_ptr <= '0;
         operand_pending <= 1'b0;
      end else if (wr && is_ctrl && (ofs == OFS_PROG_PTR)) begin
         prog_ptr <= dat_i[PTR_W-1:0];
         operand_pending <= 1'b0;
      end else if (app_wr && app_ok) begin
         prog_ptr <= prog_ptr + 1'b1;
         operand_pending <= !operand_pending && (app_need == 2'd2);
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         class_addr <= '0;
      end else if (wr && is_ctrl && (ofs == OFS_ADDR_CLASS)) begin
         class_addr <= dat_i[BIT_AW-1:0];
      end
   end

   // running xor kept in step with every program and register write; the self-test scan loads it from memory, later scans only compare against it
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         chk_state <= CHK_IDLE;
         chk_idx <= '0;
         acc <= '0;
         run_sum <= '0;
         learned <= 1'b0;
         selftest_ok <= 1'b0;
         csum_fault <= 1'b0;
      end else begin
         if (wr && is_prog) begin
            run_sum <= run_sum ^ prog_mem[prog_idx] ^ prog_new;
         end else if (app_wr && app_ok) begin
            run_sum <= run_sum ^ prog_mem[prog_ptr[PROG_AW-1:0]] ^ app_word;
         end else if (wr && (is_dreg || is_tc)) begin
            run_sum <= run_sum ^ {8'h0, reg_table[reg_idx] ^ reg_new};
         end else if (wr && is_fp) begin
            run_sum <= run_sum ^ {8'h0, reg_table[fp_lo] ^ fp_lo_new ^ reg_table[fp_hi] ^ fp_hi_new};
         end else if (chk_state == CHK_DONE && !learned) begin
            run_sum <= acc;
         end
         if (wr && is_ctrl && (ofs == OFS_CTRL) && dat_i[CTRL_CLR_FAULT]) begin
            csum_fault <= 1'b0;
         end
         case (chk_state)
            CHK_IDLE: begin
               // the first scan after reset is the self-test
               if (start_chk || !learned) begin
                  chk_state <= CHK_SCAN;
                  chk_idx <= '0;
                  acc <= '0;
               end
            end
            CHK_SCAN: begin
               acc <= acc ^ prog_mem[chk_idx]
                      ^ ((chk_idx < PROG_AW'(REG_DEPTH)) ? {8'h0, reg_table[chk_idx[REG_AW-1:0]]} : '0);
               chk_idx <= chk_idx + 1'b1;
               if (chk_idx == SCAN_LAST) begin
                  chk_state <= CHK_DONE;
               end
            end
            CHK_DONE: begin
               chk_state <= CHK_IDLE;
               if (!learned) begin
                  learned <= 1'b1;
                  selftest_ok <= 1'b1;
               end else if (acc != run_sum) begin
                  csum_fault <= 1'b1;
               end
            end
            default: chk_state <= CHK_IDLE;
         endcase
      end
   end

   assign events[IRQ_SELFTEST] = (chk_state == CHK_DONE) && !learned;
   assign events[IRQ_CSUM_FAULT] = (chk_state == CHK_DONE) && learned && (acc != run_sum);
   assign events[IRQ_MODE] = (mode != mode_prev);
   assign events[IRQ_BAT_LOW] = bat_prev & ~bat_sync;
   assign events[IRQ_PROG_FULL] = app_wr & ~app_ok;

   // set beats a same-cycle write-one clear
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         irq_status <= '0;
         irq_mask <= '0;
         irq_o <= 1'b0;
      end else begin
         if (wr && is_ctrl && (ofs == OFS_IRQ_STATUS)) begin
            irq_status <= (irq_status & ~dat_i[IRQ_W-1:0]) | events;
         end else begin
            irq_status <= irq_status | events;
         end
         if (wr && is_ctrl && (ofs == OFS_IRQ_MASK)) begin
            irq_mask <= dat_i[IRQ_W-1:0];
         end
         irq_o <= |(irq_status & irq_mask);
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         run_led_o <= 1'b0;
         pass_led_o <= 1'b0;
         battery_good_indicator_o <= 1'b0;
         force_led_o <= 1'b0;
         checksum_fault_o <= 1'b0;
      end else begin
         run_led_o <= ((mode == MODE_DISABLE) || (mode == MODE_RUN)) && scanning_i;
         pass_led_o <= selftest_ok && !chk_busy;
         battery_good_indicator_o <= bat_sync;
         force_led_o <= forced_scan_i && scanning_i;
         checksum_fault_o <= csum_fault;
      end
   end
endmodule : plc_cpu_status

// File: design/plc_status_pkg.sv
package plc_status_pkg;
   localparam int unsigned PROG_DEPTH = 8192;
   localparam int unsigned PROG_W = 24;
   localparam int unsigned PROG_AW = 13;
   localparam int unsigned PTR_W = 14;
   localparam int unsigned BIT_DEPTH = 4096;
   localparam int unsigned BIT_AW = 12;
   localparam int unsigned REG_DEPTH = 4096;
   localparam int unsigned REG_W = 16;
   localparam int unsigned REG_AW = 12;
   localparam int unsigned PAIR_AW = 11;

   // bus address fields
   localparam int unsigned RGN_LSB = 16;
   localparam int unsigned RGN_W = 4;
   localparam int unsigned TOP_LSB = 20;
   localparam int unsigned TOP_W = 12;
   localparam int unsigned OFS_W = 8;
   localparam int unsigned IDX_LSB = 2;
   localparam int unsigned DREG_BIT = 14;
   localparam int unsigned PAIR_SEL_BIT = 15;
   localparam int unsigned PAIR_GAP_BIT = 14;
   localparam int unsigned FP_GAP_BIT = 13;
   localparam int unsigned TC_FIELD_BIT = 2;
   localparam int unsigned TC_IDX_LSB = 3;

   localparam logic [RGN_W-1:0] RGN_CTRL = 4'h0;
   localparam logic [RGN_W-1:0] RGN_DATA = 4'h1;
   localparam logic [RGN_W-1:0] RGN_PROG = 4'h2;
   localparam logic [RGN_W-1:0] RGN_PAIR = 4'h3;

   localparam logic [OFS_W-1:0] OFS_STATUS = 8'h00;
   localparam logic [OFS_W-1:0] OFS_IRQ_STATUS = 8'h04;
   localparam logic [OFS_W-1:0] OFS_IRQ_MASK = 8'h08;
   localparam logic [OFS_W-1:0] OFS_CTRL = 8'h0c;
   localparam logic [OFS_W-1:0] OFS_PROG_APPEND = 8'h10;
   localparam logic [OFS_W-1:0] OFS_PROG_PTR = 8'h14;
   localparam logic [OFS_W-1:0] OFS_CHECKSUM = 8'h18;
   localparam logic [OFS_W-1:0] OFS_ADDR_CLASS = 8'h1c;

   localparam int unsigned CTRL_START = 0;
   localparam int unsigned CTRL_CLR_FAULT = 1;

   localparam int unsigned IRQ_SELFTEST = 0;
   localparam int unsigned IRQ_CSUM_FAULT = 1;
   localparam int unsigned IRQ_MODE = 2;
   localparam int unsigned IRQ_BAT_LOW = 3;
   localparam int unsigned IRQ_PROG_FULL = 4;
   localparam int unsigned IRQ_W = 5;

   // keyswitch pin codes
   localparam logic [1:0] PIN_PROGRAM = 2'h0;
   localparam logic [1:0] PIN_DISABLE = 2'h1;
   localparam logic [1:0] PIN_RUN = 2'h2;

   localparam int unsigned VAR_SMALL = 0;
   localparam int unsigned VAR_MEDIUM = 1;
   localparam int unsigned VAR_LARGE = 2;
   localparam logic [BIT_AW-1:0] REAL_LAST_SMALL = 12'd255;
   localparam logic [BIT_AW-1:0] REAL_LAST_MEDIUM = 12'd639;
   localparam logic [BIT_AW-1:0] REAL_LAST_LARGE = 12'd2039;

   localparam int unsigned OPC_LSB = 16;
   localparam int unsigned OPC_W = 8;
   localparam logic [OPC_W-1:0] OPC_FP_CONST = 8'h30;
   localparam logic [OPC_W-1:0] OPC_SUB_JUMP = 8'h40;
   localparam logic [OPC_W-1:0] OPC_ON_DELAY = 8'h50;
   localparam logic [OPC_W-1:0] OPC_OFF_DELAY = 8'h51;

   typedef enum logic [1:0] {MODE_PROGRAM, MODE_DISABLE, MODE_RUN} mode_t;
   typedef enum logic [1:0] {CHK_IDLE, CHK_SCAN, CHK_DONE} chk_state_t;

   function automatic logic [1:0] instr_words(input logic [OPC_W-1:0] op);
      case (op)
         OPC_FP_CONST, OPC_SUB_JUMP, OPC_ON_DELAY, OPC_OFF_DELAY: instr_words = 2'd2;
         default: instr_words = 2'd1;
      endcase
   endfunction : instr_words
endpackage : plc_status_pkg

// File: dv/plc_cpu_status_props.sv
`timescale 1ns/100ps
module plc_cpu_status_props #(
   parameter int unsigned VARIANT = plc_status_pkg::VAR_LARGE
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic [31:0] dat_o,
   input wire logic we_i,
   input wire logic cyc_i,
   input wire logic stb_i,
   input wire logic ack_o,
   input wire logic [1:0] mode_sel_i,
   input wire logic battery_ok_i,
   input wire logic scanning_i,
   input wire logic forced_scan_i,
   input wire logic run_led_o,
   input wire logic pass_led_o,
   input wire logic battery_good_indicator_o,
   input wire logic force_led_o,
   input wire logic irq_o
);
   import plc_status_pkg::*;
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   // a write may sit behind a full checksum scan, so the wait is counted, not unrolled
   logic [13:0] wait_cnt;
   always_ff @(posedge clk_i) begin
      if (rst_i || !(cyc_i && stb_i) || ack_o) begin
         wait_cnt <= 14'h0;
      end else begin
         wait_cnt <= wait_cnt + 14'h1;
      end
   end
   chk_ack_pulse: assert property (ack_o |=> !ack_o)
      else $error("ack held longer than one cycle");
   chk_read_prompt: assert property ((cyc_i && stb_i && !we_i && !ack_o) |=> ack_o)
      else $error("read not answered in the next cycle");
   chk_ack_bound: assert property (wait_cnt <= 14'h2004)
      else $error("access waited longer than one checksum scan");
   chk_data_hold: assert property (!ack_o |-> $stable(dat_o))
      else $error("read data changed without an ack");
   chk_run_scan: assert property (!scanning_i |=> !run_led_o)
      else $error("run indicator lit without a scan");
   chk_run_mode: assert property ((mode_sel_i == PIN_PROGRAM) [*6] |=> !run_led_o)
      else $error("run indicator lit in program position");
   chk_force_led: assert property ((forced_scan_i && scanning_i) |=> force_led_o)
      else $error("force indicator missed a forced scan");
   chk_bat_track: assert property (battery_ok_i [*4] |=> battery_good_indicator_o)
      else $error("battery indicator off while battery good");
   chk_reset_quiet: assert property ($fell(rst_i) |-> !(run_led_o || pass_led_o || ack_o || irq_o))
      else $error("indicator or ack active right after reset");
   cov_read: cover property (ack_o && !we_i);
   cov_stall: cover property ((wait_cnt > 14'h0100) ##1 ack_o);
   cov_run: cover property ($rose(run_led_o));
   cov_force: cover property ($rose(force_led_o));
endmodule : plc_cpu_status_props
bind plc_cpu_status plc_cpu_status_props #(.VARIANT(VARIANT)) u_props (
   .clk_i, .rst_i, .dat_o, .we_i, .cyc_i, .stb_i, .ack_o, .mode_sel_i, .battery_ok_i, .scanning_i,
   .forced_scan_i, .run_led_o, .pass_led_o, .battery_good_indicator_o, .force_led_o, .irq_o
);

// File: dv/plc_panel_model.sv
`timescale 1ns/100ps
module plc_panel_model (
   input wire logic clk_i,
   input wire logic [1:0] key_i,
   input wire logic bat_i,
   input wire logic scan_i,
   input wire logic force_i,
   output logic [1:0] mode_sel_o,
   output logic battery_ok_o,
   output logic scanning_o,
   output logic forced_scan_o
);
   // switch and battery are unclocked; the key shows the open code between detents
   initial begin
      mode_sel_o = 2'h0;
      battery_ok_o = 1'b0;
      scanning_o = 1'b0;
      forced_scan_o = 1'b0;
      forever begin
         @(key_i or bat_i);
         #13;
         battery_ok_o = bat_i;
         if (mode_sel_o !== key_i) begin
            mode_sel_o = 2'h3;
            #70;
            mode_sel_o = key_i;
         end
      end
   end
   // a forced contact is only met while the program is being scanned
   always @(posedge clk_i) begin
      scanning_o <= scan_i;
      forced_scan_o <= scan_i & force_i;
   end
endmodule : plc_panel_model

// File: dv/tb_plc_cpu_status.sv
`timescale 1ns/100ps
module tb_plc_cpu_status;
   import plc_status_pkg::*;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic [31:0] adr_i = 32'h0;
   logic [31:0] dat_i = 32'h0;
   logic we_i = 1'b0;
   logic [3:0] sel_i = 4'h0;
   logic cyc_i = 1'b0;
   logic stb_i = 1'b0;
   logic [1:0] key_pos = PIN_PROGRAM;
   logic bat = 1'b0;
   logic scan = 1'b0;
   logic force_on = 1'b0;
   logic [31:0] dat_o;
   logic [31:0] q;
   logic [1:0] mode_sel_i;
   logic ack_o, battery_ok_i, scanning_i, forced_scan_i, run_led_o, pass_led_o;
   logic battery_good_indicator_o, force_led_o, checksum_fault_o, irq_o;
   logic [7:0] ops [4] = '{OPC_FP_CONST, OPC_SUB_JUMP, OPC_ON_DELAY, OPC_OFF_DELAY};
   logic [1:0] keys [3] = '{PIN_DISABLE, PIN_PROGRAM, PIN_RUN};
   logic [2:0] runs = 3'b101;
   int errors = 0;
   int n_compared = 0;
   int i;
   initial begin
      forever #25 clk_i = ~clk_i;
   end
   plc_cpu_status #(.VARIANT(VAR_LARGE)) dut (
      .clk_i, .rst_i, .adr_i, .dat_i, .dat_o, .we_i, .sel_i, .cyc_i, .stb_i, .ack_o, .mode_sel_i,
      .battery_ok_i, .scanning_i, .forced_scan_i, .run_led_o, .pass_led_o, .battery_good_indicator_o,
      .force_led_o, .checksum_fault_o, .irq_o
   );
   plc_panel_model partner (
      .clk_i, .key_i(key_pos), .bat_i(bat), .scan_i(scan), .force_i(force_on), .mode_sel_o(mode_sel_i),
      .battery_ok_o(battery_ok_i), .scanning_o(scanning_i), .forced_scan_o(forced_scan_i)
   );
   function automatic logic [31:0] ctl(input logic [7:0] o);
      return {24'h0, o};
   endfunction : ctl
   task automatic end_sim();
      $display("compared %0d errors %0d", n_compared, errors);
      if (errors == 0 && n_compared > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : end_sim
   task automatic cmp_word(input logic [31:0] exp, input logic [31:0] got);
      n_compared++;
      if (got !== exp) begin
         errors++;
         $display("CHECK FAILED t=%0t exp=%h got=%h", $time, exp, got);
      end
   endtask : cmp_word
   task automatic cmp_bit(input logic exp, input logic got);
      n_compared++;
      if (got !== exp) begin
         errors++;
         $display("CHECK FAILED t=%0t exp=%h got=%h", $time, exp, got);
      end
   endtask : cmp_bit
   // writes may stall behind a checksum scan, hence the long bound
   task automatic wb(input logic w, input logic [31:0] a, input logic [31:0] d);
      int n;
      n = 0;
      cyc_i <= 1'b1;
      stb_i <= 1'b1;
      we_i <= w;
      adr_i <= a;
      dat_i <= d;
      sel_i <= 4'hf;
      @(posedge clk_i);
      while (ack_o !== 1'b1 && n < 9000) begin
         @(posedge clk_i);
         n++;
      end
      if (n >= 9000) errors++;
      q = dat_o;
      cyc_i <= 1'b0;
      stb_i <= 1'b0;
      @(posedge clk_i);
   endtask : wb
   task automatic wait_pass();
      int n;
      n = 0;
      while (pass_led_o !== 1'b1 && n < 9000) begin
         @(posedge clk_i);
         n++;
      end
      if (n >= 9000) errors++;
   endtask : wait_pass
   task automatic do_reset();
      rst_i <= 1'b1;
      repeat (8) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
   endtask : do_reset
   initial begin
      repeat (100000) @(posedge clk_i);
      errors++;
      end_sim();
   end
   initial begin
      do_reset();
      wait_pass();
      cmp_bit(1'b1, pass_led_o);
      // memories power up unknown; fill them so the relearned checksum is defined
      for (i = 0; i < PROG_DEPTH; i++) wb(1'b1, 32'(32'h20000 + 4 * i), 32'h0);
      for (i = 0; i < REG_DEPTH; i++) wb(1'b1, 32'(32'h14000 + 4 * i), 32'h0);
      do_reset();
      wait_pass();
      wb(1'b0, ctl(OFS_IRQ_STATUS), 32'h0);
      cmp_word(32'h1, q & 32'h1);
      wb(1'b0, ctl(OFS_CHECKSUM), 32'h0);
      cmp_word(32'h0, q & 32'hffffff);
      wb(1'b1, 32'h27ffc, 32'habcdef);
      wb(1'b0, 32'h27ffc, 32'h0);
      cmp_word(32'habcdef, q & 32'hffffff);
      wb(1'b1, 32'h33ffc, 32'h1234);
      wb(1'b0, 32'h17ffc, 32'h0);
      cmp_word(32'h1234, q & 32'hffff);
      wb(1'b1, 32'h38014, 32'hbeefcafe);
      wb(1'b0, 32'h14028, 32'h0);
      cmp_word(32'hcafe, q & 32'hffff);
      wb(1'b0, 32'h1402c, 32'h0);
      cmp_word(32'hbeef, q & 32'hffff);
      wb(1'b0, ctl(OFS_CHECKSUM), 32'h0);
      cmp_word(32'habcdef ^ 32'h1234 ^ 32'hcafe ^ 32'hbeef, q & 32'hffffff);
      wb(1'b1, ctl(OFS_CTRL), 32'h1);
      repeat (4) @(posedge clk_i);
      cmp_bit(1'b0, pass_led_o);
      wait_pass();
      cmp_bit(1'b0, checksum_fault_o);
      wb(1'b1, 32'h10000, 32'h1);
      wb(1'b0, 32'h10000, 32'h0);
      cmp_word(32'h3, q & 32'h3);
      wb(1'b0, 32'h11fdc, 32'h0);
      cmp_word(32'h2, q & 32'h3);
      wb(1'b0, 32'h11fe0, 32'h0);
      cmp_word(32'h0, q & 32'h3);
      wb(1'b1, 32'h13ffc, 32'h1);
      wb(1'b0, 32'h13ffc, 32'h0);
      cmp_word(32'h1, q & 32'h3);
      wb(1'b1, ctl(OFS_ADDR_CLASS), 32'd2039);
      wb(1'b0, ctl(OFS_ADDR_CLASS), 32'h0);
      cmp_word(32'h3fbd, q & 32'h7fff);
      wb(1'b1, ctl(OFS_ADDR_CLASS), 32'd2048);
      wb(1'b0, ctl(OFS_ADDR_CLASS), 32'h0);
      cmp_word(32'h4006, q & 32'h7fff);
      for (i = 0; i < 4; i++) begin
         wb(1'b1, ctl(OFS_PROG_PTR), 32'h0);
         wb(1'b1, ctl(OFS_PROG_APPEND), {8'h0, ops[i], 16'h0});
         wb(1'b0, ctl(OFS_STATUS), 32'h0);
         cmp_word(32'h800, q & 32'h800);
         wb(1'b1, ctl(OFS_PROG_APPEND), 32'h0);
         wb(1'b0, ctl(OFS_STATUS), 32'h0);
         cmp_word(32'h0, q & 32'h800);
      end
      wb(1'b1, ctl(OFS_IRQ_STATUS), 32'h1f);
      wb(1'b1, ctl(OFS_PROG_PTR), 32'h1fff);
      wb(1'b1, ctl(OFS_PROG_APPEND), {8'h0, OPC_SUB_JUMP, 16'h0});
      wb(1'b0, ctl(OFS_IRQ_STATUS), 32'h0);
      cmp_word(32'h10, q & 32'h10);
      wb(1'b0, 32'h000f0000, 32'h0);
      cmp_word(32'h0, q);
      wb(1'b1, ctl(OFS_IRQ_STATUS), 32'h1f);
      wb(1'b1, ctl(OFS_IRQ_MASK), 32'h8);
      bat <= 1'b1;
      repeat (2) @(posedge clk_i);
      cmp_bit(1'b0, battery_good_indicator_o);
      repeat (6) @(posedge clk_i);
      cmp_bit(1'b1, battery_good_indicator_o);
      cmp_bit(1'b0, irq_o);
      bat <= 1'b0;
      repeat (8) @(posedge clk_i);
      cmp_bit(1'b0, battery_good_indicator_o);
      cmp_bit(1'b1, irq_o);
      wb(1'b1, ctl(OFS_IRQ_MASK), 32'h0);
      @(posedge clk_i);
      cmp_bit(1'b0, irq_o);
      wb(1'b1, ctl(OFS_IRQ_STATUS), 32'h8);
      wb(1'b0, ctl(OFS_IRQ_STATUS), 32'h0);
      cmp_word(32'h0, q & 32'h8);
      scan <= 1'b1;
      for (i = 0; i < 3; i++) begin
         key_pos <= keys[i];
         repeat (10) @(posedge clk_i);
         cmp_bit(runs[i], run_led_o);
      end
      cmp_bit(1'b0, pass_led_o);
      wait_pass();
      cmp_bit(1'b1, pass_led_o);
      cmp_bit(1'b0, checksum_fault_o);
      force_on <= 1'b1;
      repeat (3) @(posedge clk_i);
      cmp_bit(1'b1, force_led_o);
      scan <= 1'b0;
      repeat (3) @(posedge clk_i);
      cmp_bit(1'b0, force_led_o);
      cmp_bit(1'b0, run_led_o);
      // key moves must have flagged a mode change, and the rerun scan no fault
      wb(1'b0, ctl(OFS_IRQ_STATUS), 32'h0);
      cmp_word(32'h4, q & 32'h7);
      end_sim();
   end
endmodule : tb_plc_cpu_status
